//--- tcfd_decoder.v
// Uplink command frame decoder: sync hunt, frame split, checks
`timescale 1ns/1ps
`default_nettype none
`include "tcfd_defs.vh"

module tcfd_decoder (
  input  wire        core_clk,
  input  wire        resetn,
  input  wire        bit_in,
  input  wire        bit_valid,
  input  wire [15:0] sync_address_word,
  output reg         sync_locked,
  output reg         polarity_inv,
  output reg         frame_valid,
  output reg         frame_reject,
  output reg         msg_end,
  output reg  [2:0]  cmd_mode,
  output reg  [5:0]  cmd_dest,
  output reg  [23:0] cmd_payload,
  output reg  [1:0]  mode_copy_ok,
  output reg  [5:0]  data_copy_ok,
  output reg  [15:0] frame_count
);

  // One-hot states
  localparam [2:0] ST_HUNT = 3'b001;
  localparam [2:0] ST_BODY = 3'b010;
  localparam [2:0] ST_TAIL = 3'b100;

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [6:0]  cnt_q;
  reg  [6:0]  cnt_d;
  reg  [15:0] sync_q;
  reg  [79:0] body_q;
  reg         inv_q;
  reg         inv_d;

  wire        bit_eff;
  wire [15:0] sync_win;
  wire        hit_true;
  wire        hit_inv;

  // Mode code check
  function tcfd_mode_valid;
    input [3:0] m;
    begin
      case (m)
        `TCFD_MODE1,
        `TCFD_MODE2,
        `TCFD_MODE3,
        `TCFD_MODE4,
        `TCFD_MODE5,
        `TCFD_MODE6: tcfd_mode_valid = 1'b1;
        default:     tcfd_mode_valid = 1'b0;
      endcase
    end
  endfunction

  // Mode code to mode number 1..6, zero if not a codeword
  function [2:0] tcfd_mode_num;
    input [3:0] m;
    begin
      case (m)
        `TCFD_MODE1: tcfd_mode_num = 3'h1;
        `TCFD_MODE2: tcfd_mode_num = 3'h2;
        `TCFD_MODE3: tcfd_mode_num = 3'h3;
        `TCFD_MODE4: tcfd_mode_num = 3'h4;
        `TCFD_MODE5: tcfd_mode_num = 3'h5;
        `TCFD_MODE6: tcfd_mode_num = 3'h6;
        default:     tcfd_mode_num = 3'h0;
      endcase
    end
  endfunction

  // Complemented sync flips every later bit of the frame
  assign bit_eff  = bit_in ^ inv_q;
  // Newest bit enters at the bottom, so first bit ends on top
  assign sync_win = {sync_q[14:0], bit_eff};

  // Correlator sees the window including the bit now arriving
  tcfd_sync_corr u_corr (
    .window     (sync_win),
    .pattern    (sync_address_word),
    .match_true (hit_true),
    .match_inv  (hit_inv)
  );

  // Frame body fields, in arrival order
  wire [3:0] mode_a;
  wire [3:0] mode_b;
  assign mode_a = body_q[`TCFD_MODE_A_TOP -: 4];
  assign mode_b = body_q[`TCFD_MODE_B_TOP -: 4];

  // Six data copies: A, A again, B, B again, C, C again
  wire [5:0]  copy_ok;
  wire [47:0] copy_info;

  genvar k;
  generate
    for (k = 0; k < 6; k = k + 1) begin : g_word
      tcfd_word_chk u_chk (
        .word    (body_q[`TCFD_WORD0_TOP - 12*k -: 12]),
        .word_ok (copy_ok[k]),
        .info    (copy_info[8*k +: 8])
      );
    end
  endgenerate

  // Mode acceptance: exactly one valid copy, or two equal ones
  wire       mva;
  wire       mvb;
  wire       mode_ok;
  wire [3:0] mode_sel;
  assign mva      = tcfd_mode_valid(mode_a);
  assign mvb      = tcfd_mode_valid(mode_b);
  assign mode_ok  = (mva ^ mvb) | (mva & mvb & (mode_a == mode_b));
  assign mode_sel = mva ? mode_a : mode_b;

  // Each command needs one good copy; first copy preferred
  wire       cmd_a_ok;
  wire       cmd_b_ok;
  wire       cmd_c_ok;
  wire [7:0] cmd_a;
  wire [7:0] cmd_b;
  wire [7:0] cmd_c;
  assign cmd_a_ok = copy_ok[0] | copy_ok[1];
  assign cmd_b_ok = copy_ok[2] | copy_ok[3];
  assign cmd_c_ok = copy_ok[4] | copy_ok[5];
  assign cmd_a    = copy_ok[0] ? copy_info[7:0]   : copy_info[15:8];
  assign cmd_b    = copy_ok[2] ? copy_info[23:16] : copy_info[31:24];
  assign cmd_c    = copy_ok[4] ? copy_info[39:32] : copy_info[47:40];

  // Content of the frame just collected is good
  wire body_ok;
  assign body_ok = mode_ok & cmd_a_ok & cmd_b_ok & cmd_c_ok;

  // Last bit of a trailing sync window arrives this cycle
  wire tail_end;
  assign tail_end = state_q[2] & bit_valid & (cnt_q == `TCFD_SYNC_LAST);

  // Next state: hunt for sync, take body, check trailing sync
  always @* begin
    state_d = state_q;
    cnt_d   = cnt_q;
    inv_d   = inv_q;
    case (state_q)
      ST_HUNT: begin
        // Preamble bits just slide through the window
        cnt_d = 7'h00;
        if (bit_valid && (hit_true || hit_inv)) begin
          state_d = ST_BODY;
          inv_d   = hit_inv & ~hit_true;
        end
      end
      ST_BODY: begin
        if (bit_valid) begin
          if (cnt_q == `TCFD_BODY_LAST) begin
            state_d = ST_TAIL;
            cnt_d   = 7'h00;
          end else begin
            cnt_d = cnt_q + 7'h01;
          end
        end
      end
      ST_TAIL: begin
        if (bit_valid) begin
          if (cnt_q == `TCFD_SYNC_LAST) begin
            cnt_d = 7'h00;
            // Window is already polarity corrected here
            if (hit_true) begin
              state_d = ST_BODY;
            end else begin
              // Not a sync word: closing word of the message
              state_d = ST_HUNT;
              inv_d   = 1'b0;
            end
          end else begin
            cnt_d = cnt_q + 7'h01;
          end
        end
      end
      default: begin
        state_d = ST_HUNT;
        cnt_d   = 7'h00;
        inv_d   = 1'b0;
      end
    endcase
  end

  // State, counter and polarity registers
  always @(posedge core_clk) begin
    if (!resetn) begin
      state_q <= ST_HUNT;
      cnt_q   <= 7'h00;
      inv_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      inv_q   <= inv_d;
    end
  end

  // Shift registers; body only moves while a frame is taken
  always @(posedge core_clk) begin
    if (!resetn) begin
      sync_q <= 16'h0000;
      body_q <= 80'h0;
    end else if (bit_valid) begin
      sync_q <= sync_win;
      if (state_q[1]) begin
        body_q <= {body_q[78:0], bit_eff};
      end
    end
  end

  // Link status levels for telemetry
  always @(posedge core_clk) begin
    if (!resetn) begin
      sync_locked  <= 1'b0;
      polarity_inv <= 1'b0;
    end else begin
      sync_locked  <= ~state_d[0];
      polarity_inv <= inv_d;
    end
  end

  // Frame verdict pulses; one cycle long, recomputed every cycle
  always @(posedge core_clk) begin
    if (!resetn) begin
      frame_valid  <= 1'b0;
      frame_reject <= 1'b0;
      msg_end      <= 1'b0;
    end else begin
      frame_valid  <= tail_end & hit_true & body_ok;
      frame_reject <= tail_end & ~(hit_true & body_ok);
      msg_end      <= tail_end & ~hit_true;
    end
  end

  // Per-copy check results, shown for every completed frame
  always @(posedge core_clk) begin
    if (!resetn) begin
      mode_copy_ok <= 2'b00;
      data_copy_ok <= 6'h00;
    end else if (tail_end) begin
      mode_copy_ok <= {mvb, mva};
      data_copy_ok <= copy_ok;
    end
  end

  // Accepted command and its distribution select
  // Held until the next good frame so a rejected one never
  // disturbs what users already latched.
  always @(posedge core_clk) begin
    if (!resetn) begin
      cmd_mode    <= 3'h0;
      cmd_dest    <= 6'h00;
      cmd_payload <= 24'h000000;
    end else if (tail_end && hit_true && body_ok) begin
      cmd_mode    <= tcfd_mode_num(mode_sel);
      cmd_dest    <= 6'h01 << (tcfd_mode_num(mode_sel) - 3'h1);
      cmd_payload <= {cmd_a, cmd_b, cmd_c};
    end
  end

  // Count of good frames; wraps without saturating
  always @(posedge core_clk) begin
    if (!resetn) begin
      frame_count <= 16'h0000;
    end else if (tail_end && hit_true && body_ok) begin
      frame_count <= frame_count + 16'h0001;
    end
  end

endmodule
`default_nettype wire

//--- tcfd_decoder_assertions.sv
// Property checker for the uplink command frame decoder
`timescale 1ns/1ps
`default_nettype none
module tcfd_chk (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        bit_valid,
  input wire logic        sync_locked,
  input wire logic        frame_valid,
  input wire logic        frame_reject,
  input wire logic        msg_end,
  input wire logic [2:0]  cmd_mode,
  input wire logic [5:0]  cmd_dest,
  input wire logic [23:0] cmd_payload,
  input wire logic [5:0]  data_copy_ok,
  input wire logic [15:0] frame_count
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Verdicts are single, exclusive pulses
  property p_excl; !(frame_valid && frame_reject); endproperty
  a_excl: assert property (p_excl) else $error("accept and reject together");
  property p_pulse; frame_valid |=> !frame_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("accept pulse too long");
  property p_end; msg_end |-> frame_reject && !sync_locked; endproperty
  a_end: assert property (p_end) else $error("end without reject or unlock");
  property p_dest; frame_valid |-> cmd_dest == 6'h01 << (cmd_mode - 3'h1); endproperty
  a_dest: assert property (p_dest) else $error("destination not one-hot of mode");
  property p_mode; frame_valid |-> cmd_mode inside {[3'h1:3'h6]}; endproperty
  a_mode: assert property (p_mode) else $error("mode out of range");
  property p_cnt; frame_valid |-> frame_count == $past(frame_count) + 16'h0001; endproperty
  a_cnt: assert property (p_cnt) else $error("frame count not advanced");
  // Rejected frames must leave commands alone
  property p_hold; !frame_valid |-> $stable(cmd_payload) && $stable(cmd_mode); endproperty
  a_hold: assert property (p_hold) else $error("command changed without accept");
  property p_data;
    frame_valid |-> |data_copy_ok[1:0] && |data_copy_ok[3:2] && |data_copy_ok[5:4];
  endproperty
  a_data: assert property (p_data) else $error("accept with a bad command");
  property p_lock; $rose(sync_locked) |-> $past(bit_valid); endproperty
  a_lock: assert property (p_lock) else $error("lock without a taken bit");
endmodule
bind tcfd_decoder tcfd_chk chk_u (.core_clk(core_clk), .resetn(resetn),
  .bit_valid(bit_valid), .sync_locked(sync_locked), .frame_valid(frame_valid),
  .frame_reject(frame_reject), .msg_end(msg_end), .cmd_mode(cmd_mode),
  .cmd_dest(cmd_dest), .cmd_payload(cmd_payload), .data_copy_ok(data_copy_ok),
  .frame_count(frame_count));
`default_nettype wire

//--- tcfd_defs.vh
// Constants for the uplink command frame decoder
`ifndef TCFD_DEFS_VH
`define TCFD_DEFS_VH

// Message layout in bits
`define TCFD_PRE_BITS     128
`define TCFD_FRAME_BITS   96
`define TCFD_EOM_BITS     16
`define TCFD_SYNC_BITS    16
`define TCFD_ADDR_BITS    7
`define TCFD_BODY_BITS    80
`define TCFD_MODE_BITS    4
`define TCFD_WORD_BITS    12
`define TCFD_INFO_BITS    8
`define TCFD_MIN_DIST     3

// Sync recognition threshold
`define TCFD_MATCH_MIN    15
`define TCFD_MISS_MAX     5'h01

// Counter limits
`define TCFD_BODY_LAST    7'h4f
`define TCFD_SYNC_LAST    7'h0f

// Mode codewords, first bit sent is the top bit
`define TCFD_MODE1        4'hc
`define TCFD_MODE2        4'h3
`define TCFD_MODE3        4'h6
`define TCFD_MODE4        4'h9
`define TCFD_MODE5        4'h5
`define TCFD_MODE6        4'ha

// Field positions inside the 80-bit frame body
`define TCFD_MODE_A_TOP   79
`define TCFD_MODE_B_TOP   75
`define TCFD_WORD0_TOP    71

`endif

//--- tcfd_sync_corr.v
// Sync word correlator, true and complemented match
`timescale 1ns/1ps
`default_nettype none
`include "tcfd_defs.vh"

module tcfd_sync_corr (
  input  wire [15:0] window,
  input  wire [15:0] pattern,
  output wire        match_true,
  output wire        match_inv
);

  // Count mismatching positions
  function [4:0] tcfd_diff;
    input [15:0] a;
    input [15:0] b;
    integer      i;
    begin
      tcfd_diff = 5'h00;
      for (i = 0; i < 16; i = i + 1) begin
        tcfd_diff = tcfd_diff + {4'h0, a[i] ^ b[i]};
      end
    end
  endfunction

  // At most one wrong bit, either polarity
  assign match_true = (tcfd_diff(window, pattern) <= `TCFD_MISS_MAX);
  assign match_inv  = (tcfd_diff(~window, pattern) <= `TCFD_MISS_MAX);

endmodule
`default_nettype wire

//--- tcfd_uplink_model.sv
// Ground uplink source: serial bits with optional gaps and inversion
`timescale 1ns/1ps
`default_nettype none
`include "tcfd_defs.vh"
module tcfd_uplink_model (
  input  wire logic core_clk,
  output var  logic bit_in,
  output var  logic bit_valid
);
  logic inv = 1'b0;  // Carrier phase flipped
  logic slow = 1'b0; // Idle cycle after each bit
  initial begin
    bit_in = 1'b0;
    bit_valid = 1'b0;
  end
  // Gaps hold no bits, so the stream stays unbroken
  task automatic tx(input logic b);
    @(negedge core_clk);
    bit_in = b ^ inv;
    bit_valid = 1'b1;
    if (slow) begin
      @(negedge core_clk);
      bit_in = ~bit_in; // Stale level never lingers
      bit_valid = 1'b0;
    end
  endtask
  // Acquisition run, starting with a one
  task automatic preamble();
    for (int i = 0; i < `TCFD_PRE_BITS; i++) tx(~i[0]);
  endtask
  task automatic idle();
    @(negedge core_clk);
    bit_in = ~bit_in;
    bit_valid = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tcfd_word_chk.v
// Data word checker for the shortened (12,8) Hamming code
`timescale 1ns/1ps
`default_nettype none
`include "tcfd_defs.vh"

module tcfd_word_chk (
  input  wire [11:0] word,
  output wire        word_ok,
  output wire [7:0]  info
);

  wire [7:0] b;
  wire [3:0] p;
  wire [3:0] syn;

  // First bit received sits on top: B0 first, P3 last
  assign b = {word[4], word[5], word[6], word[7],
              word[8], word[9], word[10], word[11]};
  assign p = {word[0], word[1], word[2], word[3]};

  // Parity from (15,11) positions with three data bits dropped
  assign syn[0] = p[0] ^ b[0] ^ b[1] ^ b[3] ^ b[4] ^ b[6];
  assign syn[1] = p[1] ^ b[0] ^ b[2] ^ b[3] ^ b[5] ^ b[6];
  assign syn[2] = p[2] ^ b[1] ^ b[2] ^ b[3] ^ b[7];
  assign syn[3] = p[3] ^ b[4] ^ b[5] ^ b[6] ^ b[7];

  // Any nonzero syndrome rejects the copy
  assign word_ok = (syn == 4'h0);
  assign info    = b;

endmodule
`default_nettype wire

//--- telecommand_frame_decoder_tb.sv
// Self-checking bench for the uplink command frame decoder
`timescale 1ns/1ps
`default_nettype none
`include "tcfd_defs.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module telecommand_frame_decoder_tb;
  localparam logic [15:0] SYNC = 16'h76a5; // Strap value, arbitrary
  localparam logic [15:0] EOM  = 16'h0f0f; // End word, arbitrary
  logic        core_clk = 1'b0, resetn = 1'b0, pol = 1'b0;
  logic        bit_in, bit_valid, sync_locked, polarity_inv;
  logic        frame_valid, frame_reject, msg_end;
  logic [2:0]  cmd_mode, em = 3'h0;
  logic [5:0]  cmd_dest, data_copy_ok;
  logic [23:0] cmd_payload, ep = 24'h0;
  logic [1:0]  mode_copy_ok;
  logic [15:0] frame_count, fc = 16'h0;
  logic [36:0] q[$];
  logic [3:0]  mc[6];
  logic [15:0] se = 16'h0; // Trailing sync error mask
  int          error_cnt = 0, tests_run = 0;
  tcfd_decoder dut_u (.core_clk(core_clk), .resetn(resetn), .bit_in(bit_in),
    .bit_valid(bit_valid), .sync_address_word(SYNC), .sync_locked(sync_locked),
    .polarity_inv(polarity_inv), .frame_valid(frame_valid), .frame_reject(frame_reject),
    .msg_end(msg_end), .cmd_mode(cmd_mode), .cmd_dest(cmd_dest), .cmd_payload(cmd_payload),
    .mode_copy_ok(mode_copy_ok), .data_copy_ok(data_copy_ok), .frame_count(frame_count));
  tcfd_uplink_model src_u (.core_clk(core_clk), .bit_in(bit_in), .bit_valid(bit_valid));
  initial forever #50 core_clk = ~core_clk;
  // Send order B0..B7 then P0..P3
  function automatic logic [11:0] enc(input logic [7:0] d);
    enc = {d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7], d[0]^d[1]^d[3]^d[4]^d[6],
      d[0]^d[2]^d[3]^d[5]^d[6], d[1]^d[2]^d[3]^d[7], d[4]^d[5]^d[6]^d[7]};
  endfunction
  function automatic logic vld(input logic [3:0] c);
    vld = c inside {`TCFD_MODE1, `TCFD_MODE2, `TCFD_MODE3, `TCFD_MODE4, `TCFD_MODE5,
      `TCFD_MODE6};
  endfunction
  task automatic s16(input logic [15:0] v);
    for (int i = 15; i >= 0; i--) src_u.tx(v[i]);
  endtask
  task automatic s80(input logic [79:0] v);
    for (int i = 79; i >= 0; i--) src_u.tx(v[i]);
  endtask
  // Body with a fault mask, then the sync that closes it
  task automatic frame(input int m, input logic [23:0] p, input logic [79:0] x);
    logic [79:0] b;
    logic [5:0]  dk;
    logic        ok;
    logic        lost;
    b = {mc[m-1], mc[m-1], enc(p[23:16]), enc(p[23:16]), enc(p[15:8]), enc(p[15:8]),
      enc(p[7:0]), enc(p[7:0])} ^ x;
    for (int k = 0; k < 6; k++) dk[k] = (x[71-12*k -: 12] == 12'h0);
    // Two or more wrong trailing bits end the message instead
    lost = ($countones(se) > 1);
    ok = (vld(b[79:76]) != vld(b[75:72]) || (vld(b[79:76]) && b[79:76] == b[75:72]))
      && |dk[1:0] && |dk[3:2] && |dk[5:4] && !lost;
    q.push_back({ok, lost, 3'(m), p, vld(b[75:72]), vld(b[79:76]), dk});
    s80(b);
    s16(SYNC ^ se);
  endtask
  task automatic rnd_frames(input int n);
    repeat (n) frame($urandom_range(6, 1), 24'($urandom), 80'h0);
  endtask
  // End word then filler, so the last window fails
  task automatic close();
    s16(EOM);
    s80(80'h0);
    q.push_back({2'b01, 35'h0});
    src_u.idle();
  endtask
  always @(negedge core_clk) if (frame_valid === 1'b1 || frame_reject === 1'b1) begin
    logic [36:0] t;
    t = q.pop_front();
    `CHK({frame_valid, msg_end}, t[36:35])
    `CHK(sync_locked, !t[35])
    if (t[36]) begin
      em = t[34:32];
      ep = t[31:8];
      fc++;
      `CHK(cmd_dest, 6'h01 << (em - 3'h1))
      `CHK(polarity_inv, pol)
      `CHK(frame_count, fc)
    end
    `CHK({cmd_mode, cmd_payload}, {em, ep})
    if (!t[35]) `CHK({mode_copy_ok, data_copy_ok}, t[7:0])
  end
  task automatic results();
    $display("Checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Whole run is about 3500 cycles
  initial begin
    repeat (10000) @(posedge core_clk);
    error_cnt++;
    results();
  end
  initial begin
    mc = '{`TCFD_MODE1, `TCFD_MODE2, `TCFD_MODE3, `TCFD_MODE4, `TCFD_MODE5, `TCFD_MODE6};
    void'($urandom(31));
    repeat (4) @(negedge core_clk);
    resetn = 1'b1;
    src_u.preamble();
    s16(SYNC);
    rnd_frames(4);
    close();
    // Faulty copies; leading sync one bit off
    src_u.preamble();
    s16(SYNC ^ 16'h0100);
    frame(1, 24'($urandom), 80'h1 << 65);
    frame(2, 24'($urandom), 80'h1 << 79);
    frame(3, 24'($urandom), (80'h1 << 40) | (80'h1 << 30));
    frame(1, 24'($urandom), 80'hf << 72);
    frame(4, 24'($urandom), (80'h1 << 79) | (80'h1 << 75));
    rnd_frames(1);
    close();
    // Inverted carrier with gapped bits
    src_u.inv = 1'b1;
    src_u.slow = 1'b1;
    pol = 1'b1;
    src_u.preamble();
    s16(SYNC);
    rnd_frames(3);
    close();
    // Every mode once; trailing sync one bit off kept, two bits off ends
    src_u.inv = 1'b0;
    src_u.slow = 1'b0;
    pol = 1'b0;
    src_u.preamble();
    s16(SYNC);
    for (int m = 1; m <= 6; m++) frame(m, 24'($urandom), 80'h0);
    se = 16'h0800;
    frame(5, 24'($urandom), 80'h0);
    se = 16'h8001;
    frame(6, 24'($urandom), 80'h0);
    se = 16'h0000;
    src_u.idle();
    repeat (4) @(negedge core_clk);
    `CHK(q.size(), 0)
    results();
  end
endmodule
`default_nettype wire
